// ### hw/sfoui_core.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) Masked single overflow: set O and P, infinity or max normal by mode and sign.
// (RULE_02) Masked double overflow: same selection with double max normal, O and P set.
// (RULE_03) Unmasked overflow: rounded result scaled down by 2^192 or 2^1536, P if inexact.
// (RULE_04) Underflow when rounded unbounded-exponent result is below smallest normal.
// (RULE_05) Masked underflow: zero, denormal or normal; U and P only when inexact.
// (RULE_06) Unmasked underflow: result scaled up by 2^192 or 2^1536, U set, P if inexact.
// (RULE_07) Precision raised whenever the result is not exactly representable.
// (RULE_08) Masked inexact returns bounded rounded result and sets P.
// (RULE_09) Unmasked inexact traps only without unmasked overflow or underflow.
// (RULE_10) Rounding mode comes from control register; truncating conversions round to zero.
// (RULE_11) Status flags are sticky per element; unmasked flagged condition signals exception.
module sfoui_core
    import sfoui_pkg::*;
#(
    parameter int EXP_W  = 16,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [ADDR_W-1:0]       paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic                         pready_o,
    output logic                         pslverr_o,
    output logic [31:0]                  prdata_o,
    // One element from the execution pipeline
    input  wire logic                    in_valid_i,
    input  wire logic                    in_dp_i,
    input  wire logic                    in_trunc_i,
    input  wire logic                    in_sign_i,
    input  wire logic signed [EXP_W-1:0] in_exp_i,
    input  wire logic [SFOUI_MANT_W-1:0] in_mant_i,
    input  wire logic                    in_sticky_i,
    // Writeback and exception report
    output logic                         out_valid_o,
    output logic [63:0]                  out_result_o,
    output logic [2:0]                   out_flags_o,
    output logic                         out_exc_o,
    // Interrupt
    output logic                         irq_o
);

    sfoui_state_t r;
    sfoui_state_t n;

    // Rounds m away from its low drop bits; returns {inexact, rounded value}
    function automatic logic [65:0] rnd_f(
        input logic [63:0] m,
        input logic        st,
        input logic [7:0]  drop,
        input logic [1:0]  mode,
        input logic        s
    );
        logic [63:0] kept;
        logic [63:0] lostm;
        logic [63:0] gbit;
        logic        grd;
        logic        rest;
        logic        inx;
        logic        inc;
        kept  = m >> drop;
        lostm = m & ~({64{1'b1}} << drop);
        gbit  = 64'h0000_0000_0000_0001 << (drop - 8'h01);
        grd   = |(lostm & gbit);
        rest  = (|(lostm & ~gbit)) | st;
        inx   = grd | rest;                              // [RULE_07]
        case (mode)
            SFOUI_RND_NEAR: inc = grd & (rest | kept[0]);
            SFOUI_RND_DOWN: inc = s & inx;
            SFOUI_RND_UP:   inc = ~s & inx;
            default:        inc = 1'b0;
        endcase
        return {inx, {1'b0, kept} + {64'h0000_0000_0000_0000, inc}};
    endfunction

    // Resolves one element; returns {exception, flags, result}
    function automatic logic [67:0] resolve_f(
        input logic                    dp,
        input logic                    s,
        input logic signed [EXP_W-1:0] ex,
        input logic [63:0]             m,
        input logic                    st,
        input logic [1:0]              mode,
        input logic [2:0]              mask
    );
        int          p;
        int          bias;
        int          emax;
        int          emin;
        int          scale;
        int          eall;
        int          e;
        int          d;
        logic [65:0] ru;
        logic [65:0] rd;
        logic [64:0] mu;
        logic        ix;
        logic        zero;
        logic        mx;
        logic [2:0]  fl;
        logic [10:0] be;
        logic [51:0] fr;
        logic [63:0] res;
        p     = dp ? SFOUI_DP_P : SFOUI_SP_P;
        bias  = dp ? SFOUI_DP_BIAS : SFOUI_SP_BIAS;
        emax  = dp ? SFOUI_DP_EMAX : SFOUI_SP_EMAX;
        emin  = dp ? SFOUI_DP_EMIN : SFOUI_SP_EMIN;
        scale = dp ? SFOUI_DP_SCALE : SFOUI_SP_SCALE;
        eall  = dp ? SFOUI_DP_EALL : SFOUI_SP_EALL;
        zero  = ~|m;
        fl    = '0;
        // Round with unbounded exponent to destination precision
        ru = rnd_f(m, st, 8'(SFOUI_MANT_W - p), mode, s);
        e  = int'(ex);
        mu = ru[64:0];
        ix = ru[65];
        if (mu[p]) begin
            // Carry out of rounding renormalises exactly
            e  = e + 1;
            mu = mu >> 1;
        end
        be = 11'(e + bias);
        fr = 52'(mu << (SFOUI_DP_P - p));
        mx = (mode == SFOUI_RND_ZERO) | ((mode == SFOUI_RND_DOWN) & ~s)
           | ((mode == SFOUI_RND_UP) & s);
        if (zero) begin
            be = '0;
            fr = '0;
        end else if (e > emax) begin
            fl[SFOUI_F_OVF] = 1'b1;
            if (mask[SFOUI_F_OVF]) begin
                // Infinity or largest finite by mode and sign
                fl[SFOUI_F_PRE] = 1'b1;                  // [RULE_01] [RULE_02]
                be = mx ? 11'(emax + bias) : 11'(eall);  // [RULE_01] [RULE_02]
                fr = mx ? '1 : '0;
            end else begin
                fl[SFOUI_F_PRE] = ix;                    // [RULE_03]
                be = 11'(e - scale + bias);              // [RULE_03]
            end
        end else if (e < emin) begin                     // [RULE_04]
            if (mask[SFOUI_F_UNF]) begin
                // Denormalise from the raw significand to avoid double rounding
                d = SFOUI_MANT_W - p + (emin - int'(ex));
                if (d > 127) begin
                    d = 127;
                end
                rd = rnd_f(m, st, 8'(d), mode, s);
                fl[SFOUI_F_UNF] = rd[65];                // [RULE_05]
                fl[SFOUI_F_PRE] = rd[65];                // [RULE_05]
                be = {10'h000, rd[p-1]};                 // Rounded up into min normal
                fr = 52'(rd[64:0] << (SFOUI_DP_P - p));
            end else begin
                fl[SFOUI_F_UNF] = 1'b1;                  // [RULE_06]
                fl[SFOUI_F_PRE] = ix;                    // [RULE_06]
                be = 11'(e + scale + bias);              // [RULE_06]
            end
        end else begin
            fl[SFOUI_F_PRE] = ix;                        // [RULE_07] [RULE_08]
        end
        if (dp) begin
            res = {s, be, fr};
        end else begin
            res = {32'h0000_0000, s, be[SFOUI_SP_EXP_W-1:0],
                   fr[SFOUI_DP_FRAC_W-1 -: SFOUI_SP_FRAC_W]};
        end
        // Precision traps only once overflow/underflow are masked or absent
        return {|(fl & ~mask), fl, res};                 // [RULE_09] [RULE_11]
    endfunction

    // Next-state logic for datapath, registers and APB
    always_comb begin
        logic [2:0]  evt;
        logic [2:0]  clr;
        logic [1:0]  emode;
        logic        acc;
        logic        hit;
        logic [31:0] rv;
        evt   = '0;
        clr   = '0;
        acc   = 1'b0;
        hit   = 1'b0;
        rv    = '0;
        // Truncating conversions ignore the programmed mode
        emode = in_trunc_i ? SFOUI_RND_ZERO : r.mode;    // [RULE_10]
        n     = r;
        n.vld = in_valid_i;
        n.exc = 1'b0;
        if (in_valid_i) begin
            {n.exc, n.flags, n.res} = resolve_f(in_dp_i, in_sign_i, in_exp_i,
                                                in_mant_i, in_sticky_i, emode, r.mask);
            evt = n.flags;
        end
        // Register decode shared by read and write
        case (paddr_i)
            ADDR_W'(SFOUI_OFF_CTRL): begin
                hit = 1'b1;
                rv[SFOUI_CTL_MODE_LSB +: 2] = r.mode;
                rv[SFOUI_CTL_MASK_LSB +: SFOUI_NFLAG] = r.mask;
            end
            ADDR_W'(SFOUI_OFF_STATUS): begin
                hit = 1'b1;
                rv[SFOUI_NFLAG-1:0] = r.status;
            end
            ADDR_W'(SFOUI_OFF_CLEAR): begin
                hit = 1'b1;
            end
            ADDR_W'(SFOUI_OFF_IRQEN): begin
                hit = 1'b1;
                rv[SFOUI_NFLAG-1:0] = r.irq_en;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // Writes land only at the completing edge of the access phase
        acc = psel_i & penable_i & r.rdy & pwrite_i & hit;
        if (acc) begin
            case (paddr_i)
                ADDR_W'(SFOUI_OFF_CTRL): begin
                    n.mode = pwdata_i[SFOUI_CTL_MODE_LSB +: 2];
                    n.mask = pwdata_i[SFOUI_CTL_MASK_LSB +: SFOUI_NFLAG];
                end
                ADDR_W'(SFOUI_OFF_CLEAR): begin
                    clr = pwdata_i[SFOUI_NFLAG-1:0];
                end
                ADDR_W'(SFOUI_OFF_IRQEN): begin
                    n.irq_en = pwdata_i[SFOUI_NFLAG-1:0];
                end
                default: begin
                    clr = '0;
                end
            endcase
        end
        // Sticky flags; a new event beats a clear in the same cycle
        n.status = (r.status & ~clr) | evt;              // [RULE_11]
        // One wait state so read data comes from a flip-flop
        if (psel_i & penable_i & ~r.rdy) begin
            n.rdy   = 1'b1;
            n.rdata = rv;
            n.err   = ~hit;
        end else begin
            n.rdy = 1'b0;
            n.err = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r <= SFOUI_STATE_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign pready_o     = psel_i & penable_i & r.rdy;
    assign pslverr_o    = psel_i & penable_i & r.rdy & r.err;
    assign prdata_o     = r.rdata;
    assign out_valid_o  = r.vld;
    assign out_result_o = r.res;
    assign out_flags_o  = r.flags;
    assign out_exc_o    = r.exc;
    assign irq_o        = |(r.status & r.irq_en);

endmodule

// ### hw/sfoui_pkg.sv
package sfoui_pkg;

    // Rounding control encodings
    localparam logic [1:0] SFOUI_RND_NEAR = 2'h0;
    localparam logic [1:0] SFOUI_RND_DOWN = 2'h1;
    localparam logic [1:0] SFOUI_RND_UP   = 2'h2;
    localparam logic [1:0] SFOUI_RND_ZERO = 2'h3;

    // Width of the incoming normalised significand (leading one at the top)
    localparam int SFOUI_MANT_W = 64;

    // Single format figures
    localparam int SFOUI_SP_P     = 24;
    localparam int SFOUI_SP_BIAS  = 127;
    localparam int SFOUI_SP_EMAX  = 127;
    localparam int SFOUI_SP_EMIN  = -126;
    localparam int SFOUI_SP_SCALE = 192;
    localparam int SFOUI_SP_EALL  = 255;
    localparam int SFOUI_SP_FRAC_W = 23;
    localparam int SFOUI_SP_EXP_W  = 8;

    // Double format figures
    localparam int SFOUI_DP_P     = 53;
    localparam int SFOUI_DP_BIAS  = 1023;
    localparam int SFOUI_DP_EMAX  = 1023;
    localparam int SFOUI_DP_EMIN  = -1022;
    localparam int SFOUI_DP_SCALE = 1536;
    localparam int SFOUI_DP_EALL  = 2047;
    localparam int SFOUI_DP_FRAC_W = 52;
    localparam int SFOUI_DP_EXP_W  = 11;

    // Flag, mask and interrupt bit positions (same layout everywhere)
    localparam int SFOUI_F_OVF = 0;
    localparam int SFOUI_F_UNF = 1;
    localparam int SFOUI_F_PRE = 2;
    localparam int SFOUI_NFLAG = 3;

    // Control register fields
    localparam int SFOUI_CTL_MODE_LSB = 0;
    localparam int SFOUI_CTL_MASK_LSB = 2;

    // APB register byte offsets
    localparam logic [11:0] SFOUI_OFF_CTRL   = 12'h000;
    localparam logic [11:0] SFOUI_OFF_STATUS = 12'h004;
    localparam logic [11:0] SFOUI_OFF_CLEAR  = 12'h008;
    localparam logic [11:0] SFOUI_OFF_IRQEN  = 12'h00C;

    // Reset values
    localparam logic [1:0] SFOUI_MODE_RST = SFOUI_RND_NEAR;
    localparam logic [2:0] SFOUI_MASK_RST = 3'h7;

    // Whole state of the unit
    typedef struct packed {
        logic [1:0]  mode;
        logic [2:0]  mask;
        logic [2:0]  status;
        logic [2:0]  irq_en;
        logic        rdy;
        logic        err;
        logic [31:0] rdata;
        logic        vld;
        logic [63:0] res;
        logic [2:0]  flags;
        logic        exc;
    } sfoui_state_t;

    localparam sfoui_state_t SFOUI_STATE_RST = '{
        mode: SFOUI_MODE_RST, mask: SFOUI_MASK_RST, default: '0};

endpackage

// ### tb/sfoui_core_props.sv
`timescale 1ns/1ps
// Port-level checks of the exception unit
module sfoui_core_props (
    // Clock, reset and bus
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pwrite_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    // Element path and interrupt
    input wire logic       in_valid_i,
    input wire logic       out_valid_o,
    input wire logic [2:0] out_flags_o,
    input wire logic       out_exc_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_access; psel_i && penable_i; endsequence
    // One wait state on every access, never zero
    property p_wait; s_setup ##1 s_access |-> !pready_o ##1 pready_o; endproperty
    a_wait: assert property (p_wait) else $error("bus ready late or early");
    property p_err; pslverr_o |-> pready_o; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_lat; in_valid_i |=> out_valid_o; endproperty
    a_lat: assert property (p_lat) else $error("result missing");
    property p_quiet; !in_valid_i |=> !out_valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("result without strobe");
    property p_exc; out_exc_o |-> out_valid_o && out_flags_o != 3'h0; endproperty
    a_exc: assert property (p_exc) else $error("exception without flag");
    // Masked overflow always carries precision
    property p_movf; out_valid_o && out_flags_o[0] && !out_exc_o |-> out_flags_o[2]; endproperty
    a_movf: assert property (p_movf) else $error("overflow lacks precision");
    property p_munf; out_valid_o && out_flags_o[1] && !out_exc_o |-> out_flags_o[2]; endproperty
    a_munf: assert property (p_munf) else $error("underflow lacks precision");
    // Interrupt rises only on a new result or an enable write
    property p_irq; $rose(irq_o) |-> out_valid_o || ($past(pready_o) && $past(pwrite_i)); endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule
bind sfoui_core sfoui_core_props i_props (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .in_valid_i  (in_valid_i),
    .out_valid_o (out_valid_o),
    .out_flags_o (out_flags_o),
    .out_exc_o   (out_exc_o),
    .irq_o       (irq_o)
);

// ### tb/sfoui_pipe_model.sv
`timescale 1ns/1ps
// Pipeline stand-in: one strobe per element, significand and sticky scrambled after it
module sfoui_pipe_model (
    input  wire logic          clk_i,
    output logic               in_valid_o,
    output logic               in_dp_o,
    output logic               in_trunc_o,
    output logic               in_sign_o,
    output logic signed [15:0] in_exp_o,
    output logic [63:0]        in_mant_o,
    output logic               in_sticky_o
);
    initial {in_valid_o, in_dp_o, in_trunc_o, in_sign_o, in_exp_o, in_mant_o, in_sticky_o} = '0;
    task automatic issue(input logic d, t, s, input logic [15:0] e, input logic [63:0] m,
                         input logic st);
        @(posedge clk_i);
        in_valid_o <= 1'b1;
        {in_dp_o, in_trunc_o, in_sign_o, in_exp_o, in_mant_o, in_sticky_o} <= {d, t, s, e, m, st};
        @(posedge clk_i);
        // Inverted so the unit cannot lean on fields held past the strobe
        in_valid_o <= 1'b0;
        {in_mant_o, in_sticky_o} <= ~{m, st};
    endtask
endmodule

// ### tb/tb_simd_fp_overflow_underflow_inexact.sv
`timescale 1ns/1ps
module tb_simd_fp_overflow_underflow_inexact;
    import sfoui_pkg::*;
    localparam logic [63:0] ONE = 64'h8000_0000_0000_0000;
    logic               clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0]        paddr_i = '0;
    logic [31:0]        pwdata_i = '0, prdata_o;
    logic               in_valid_i, in_dp_i, in_trunc_i, in_sign_i, in_sticky_i;
    logic signed [15:0] in_exp_i;
    logic [63:0]        in_mant_i, out_result_o;
    logic [2:0]         out_flags_o;
    logic               pready_o, pslverr_o, out_valid_o, out_exc_o, irq_o;
    logic [67:0]        exp_q[$];
    int                 mismatches = 0, total_checks = 0;
    always #2.5 clk_i = ~clk_i;
    sfoui_core i_dut (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .psel_i       (psel_i),
        .penable_i    (penable_i),
        .pwrite_i     (pwrite_i),
        .paddr_i      (paddr_i),
        .pwdata_i     (pwdata_i),
        .pready_o     (pready_o),
        .pslverr_o    (pslverr_o),
        .prdata_o     (prdata_o),
        .in_valid_i   (in_valid_i),
        .in_dp_i      (in_dp_i),
        .in_trunc_i   (in_trunc_i),
        .in_sign_i    (in_sign_i),
        .in_exp_i     (in_exp_i),
        .in_mant_i    (in_mant_i),
        .in_sticky_i  (in_sticky_i),
        .out_valid_o  (out_valid_o),
        .out_result_o (out_result_o),
        .out_flags_o  (out_flags_o),
        .out_exc_o    (out_exc_o),
        .irq_o        (irq_o)
    );
    sfoui_pipe_model i_pipe (.clk_i(clk_i), .in_valid_o(in_valid_i), .in_dp_o(in_dp_i),
        .in_trunc_o(in_trunc_i), .in_sign_o(in_sign_i), .in_exp_o(in_exp_i),
        .in_mant_o(in_mant_i), .in_sticky_o(in_sticky_i));
    task automatic chk(input string n, input logic [67:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bus master: hold the request until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        int n = 0;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
        r = {pslverr_o, prdata_o};
        chk("ready", pready_o, 1);
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        logic [32:0] r;
        apb(1'b0, a, '0, r);
        chk("register", r, e);
    endtask
    task automatic irq_is(input logic v);
        @(posedge clk_i);
        chk("irq", irq_o, v);
    endtask
    // Note the expected {exc, flags, result} before handing the element over
    task automatic el(input logic d, t, s, input int e, input logic [63:0] m,
                      input logic st, input logic [67:0] x);
        exp_q.push_back(x);
        i_pipe.issue(d, t, s, e[15:0], m, st);
    endtask
    function automatic logic [31:0] ovf_sp(input logic [1:0] md, input logic s);
        logic inf;
        inf = md == SFOUI_RND_NEAR || (md == SFOUI_RND_DOWN && s) || (md == SFOUI_RND_UP && !s);
        return {s, inf ? 31'h7F80_0000 : 31'h7F7F_FFFF};
    endfunction
    // Each result is matched against the oldest outstanding note
    always @(posedge clk_i)
        if (out_valid_o === 1'b1)
            chk("element", {out_exc_o, out_flags_o, out_result_o},
                exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
    initial begin
        int e;
        logic [22:0] f;
        logic s;
        void'($urandom(22288));
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(SFOUI_OFF_CTRL, 33'h0_0000_001C);
        rd(SFOUI_OFF_STATUS, 33'h0);
        rd(SFOUI_OFF_IRQEN, 33'h0);
        rd(12'h010, 33'h1_0000_0000);
        // Masked overflow in every rounding mode, both signs
        for (int md = 0; md < 4; md++) begin
            wr(SFOUI_OFF_CTRL, 32'h1C | md);
            for (int sg = 0; sg < 2; sg++)
                el(0, 0, sg[0], 128, ONE, 0, {36'h5_0000_0000, ovf_sp(md[1:0], sg[0])});
        end
        rd(SFOUI_OFF_STATUS, 33'h5);
        el(1, 0, 0, 1024, ONE, 0, {4'h5, 64'h7FEF_FFFF_FFFF_FFFF});
        wr(SFOUI_OFF_CTRL, 32'h1C);
        el(1, 0, 1, 1024, ONE, 0, {4'h5, 64'hFFF0_0000_0000_0000});
        wr(SFOUI_OFF_CTRL, 32'h18);
        el(0, 0, 0, 128, ONE, 0, {4'h9, 64'h1F80_0000});
        el(0, 0, 1, 128, ONE, 1, {4'hD, 64'h9F80_0000});
        el(1, 0, 0, 1024, ONE, 0, {4'h9, 64'h1FF0_0000_0000_0000});
        // Tiny results around the smallest normal, then directed rounding, truncation and an unmasked precision trap
        wr(SFOUI_OFF_CTRL, 32'h1C);
        el(0, 0, 0, -126, ONE, 0, {4'h0, 64'h0080_0000});
        el(0, 0, 0, -127, 64'hFFFF_FFFF_FFFF_FFFF, 0, {4'h4, 64'h0080_0000});
        el(0, 0, 1, -127, ONE, 0, {4'h0, 64'h8040_0000});
        el(0, 0, 0, -127, ONE, 1, {4'h6, 64'h0040_0000});
        el(1, 0, 0, -1023, ONE, 0, {4'h0, 64'h0008_0000_0000_0000});
        wr(SFOUI_OFF_CTRL, 32'h14);
        el(0, 0, 0, -130, ONE, 0, {4'hA, 64'h5E80_0000});
        el(1, 0, 0, -1030, ONE, 0, {4'hA, 64'h5F90_0000_0000_0000});
        wr(SFOUI_OFF_CTRL, 32'h1E);
        el(0, 0, 0, 0, ONE, 1, {4'h4, 64'h3F80_0001});
        el(0, 1, 0, 0, ONE, 1, {4'h4, 64'h3F80_0000});
        wr(SFOUI_OFF_CTRL, 32'h0C);
        el(0, 0, 0, 0, ONE, 1, {4'hC, 64'h3F80_0000});
        el(0, 0, 1, 128, ONE, 0, {4'hD, 64'hFF80_0000});
        // Random exact normals raise nothing
        wr(SFOUI_OFF_CTRL, 32'h1C);
        repeat (20) begin
            e = $urandom_range(253) - 126;
            f = 23'($urandom);
            s = 1'($urandom);
            el(0, 0, s, e, {1'b1, f, 40'h0}, 0, {36'h0, s, 8'(e + 127), f});
        end
        // Status is read-only; interrupt raised, masked, cleared
        wr(SFOUI_OFF_STATUS, 32'h0);
        rd(SFOUI_OFF_STATUS, 33'h7);
        wr(SFOUI_OFF_IRQEN, 32'h7);
        irq_is(1);
        rd(SFOUI_OFF_IRQEN, 33'h7);
        wr(SFOUI_OFF_IRQEN, 32'h0);
        irq_is(0);
        wr(SFOUI_OFF_IRQEN, 32'h7);
        wr(SFOUI_OFF_CLEAR, 32'h7);
        irq_is(0);
        rd(SFOUI_OFF_STATUS, 33'h0);
        rd(SFOUI_OFF_CLEAR, 33'h0);
        print_verdict();
    end
endmodule
